// ---- common/rftxc_cfg.svh ----
`ifndef RFTXC_CFG_SVH
`define RFTXC_CFG_SVH

// Register offsets on the parallel host port.
`define RFTXC_OFF_CRC_HIGH 6'h0E
`define RFTXC_OFF_BIT_FRAME 6'h0F
`define RFTXC_OFF_TX_CTRL 6'h11
`define RFTXC_OFF_COND 6'h12

// Reset values.
`define RFTXC_RST_BIT_FRAME 8'h00
`define RFTXC_RST_TX_CTRL 8'h58
`define RFTXC_RST_COND 8'h3F

// Field positions in the bit frame adjust register.
`define RFTXC_RXOFF_MSB 6
`define RFTXC_RXOFF_LSB 4
`define RFTXC_LAST_MSB 2
`define RFTXC_LAST_LSB 0

// Field positions in the transmitter control register.
`define RFTXC_MODSEL_MSB 6
`define RFTXC_MODSEL_LSB 5
`define RFTXC_B_INV 3
`define RFTXC_B_CW 2
`define RFTXC_B_EN 1
`define RFTXC_A_EN 0

// Field position of the conductance setting.
`define RFTXC_COND_MSB 5
`define RFTXC_COND_LSB 0

`endif

// ---- common/rftxc_pkg.sv ----
package rftxc_pkg;

  // Modulator input sources.
  typedef enum logic [1:0] {
    RFTXC_MOD_LOW,
    RFTXC_MOD_HIGH,
    RFTXC_MOD_ENCODER,
    RFTXC_MOD_EXTERNAL
  } rftxc_modsel_t;

endpackage : rftxc_pkg

// ---- common/rftxc_ant_if.sv ----
`timescale 1ns/10ps
interface rftxc_ant_if;
  logic [7:0] tx_ctrl;
  logic carrier;
  logic enc_data;
  logic ext_mod_raw;
  logic mod_in;
  logic ant_a;
  logic ant_b;

  modport regs (output tx_ctrl, output carrier, output enc_data,
    output ext_mod_raw, input mod_in, input ant_a, input ant_b);
  modport drv (input tx_ctrl, input carrier, input enc_data,
    input ext_mod_raw, output mod_in, output ant_a, output ant_b);
endinterface : rftxc_ant_if

// ---- rtl/rftxc_antenna.sv ----
`timescale 1ns/10ps
`include "rftxc_cfg.svh"
module rftxc_antenna
(
  input wire logic i_clk, // System clock.
  input wire logic i_rst, // Synchronous reset, active high.
  rftxc_ant_if.drv ant    // Control and drive signals.
);

  logic [2:0] ext_sync_r;
  logic ext_mod_r;
  logic mod_in_r;
  logic ant_a_r;
  logic ant_b_r;
  logic b_base;
  rftxc_pkg::rftxc_modsel_t sel;

  // The external modulation pin passes three stages.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ext_sync_r <= 3'h0;
    else
      ext_sync_r <= {ext_sync_r[1:0], ant.ext_mod_raw};
  end

  // The level only changes once the second and third stage agree.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ext_mod_r <= 1'b0;
    else if (ext_sync_r[1] == ext_sync_r[2])
      ext_mod_r <= ext_sync_r[2];
  end

  assign sel = rftxc_pkg::rftxc_modsel_t'(
    ant.tx_ctrl[`RFTXC_MODSEL_MSB:`RFTXC_MODSEL_LSB]);

  // Modulator input source selection.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      mod_in_r <= 1'b0;
    else
      case (sel) // see RULE_08
        rftxc_pkg::RFTXC_MOD_LOW: mod_in_r <= 1'b0;
        rftxc_pkg::RFTXC_MOD_HIGH: mod_in_r <= 1'b1;
        rftxc_pkg::RFTXC_MOD_ENCODER: mod_in_r <= ant.enc_data;
        rftxc_pkg::RFTXC_MOD_EXTERNAL: mod_in_r <= ext_mod_r;
        default: mod_in_r <= 1'b0;
      endcase
  end

  // Output B carrier before inversion: plain or gated by the modulator.
  assign b_base = ant.tx_ctrl[`RFTXC_B_CW] ? ant.carrier
    : (ant.carrier & mod_in_r); // see RULE_10

  // Antenna drivers; a disabled output sits at a constant low.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ant_a_r <= 1'b0;
      ant_b_r <= 1'b0;
    end
    else
    begin
      ant_a_r <= ant.tx_ctrl[`RFTXC_A_EN] & ant.carrier & mod_in_r;
      // see RULE_12
      ant_b_r <= ant.tx_ctrl[`RFTXC_B_EN]
        & (b_base ^ ant.tx_ctrl[`RFTXC_B_INV]); // see RULE_09 RULE_11
    end
  end

  assign ant.mod_in = mod_in_r;
  assign ant.ant_a = ant_a_r;
  assign ant.ant_b = ant_b_r;

endmodule : rftxc_antenna

// ---- rtl/rftxc_regs.sv ----
// Functional notes
// RULE_01: CRC result high byte is read-only; valid only while CRC done is set.
// RULE_02: For eight-bit CRC the high byte is undefined; here it reads zero.
// RULE_03: Receive bit offset, bits 6..4, gives FIFO position of first bit.
// RULE_04: Offset N puts first bit at N; offset 7 wraps second into next byte.
// RULE_05: Receive bit offset clears to zero when a reception completes.
// RULE_06: Final byte bit count, bits 2..0, limits last byte; zero sends all.
// RULE_07: Final byte bit count clears to zero when a transmission finishes.
// RULE_08: Modulator input: 00 low, 01 high, 10 encoder, 11 external pin.
// RULE_09: Antenna B invert bit inverts the carrier on antenna output B.
// RULE_10: Antenna B carrier-only bit gives unmodulated carrier on output B.
// RULE_11: Antenna B enable drives modulated carrier, else constant level.
// RULE_12: Antenna A enable drives modulated carrier, else constant level.
// RULE_13: Six-bit driver conductance setting is held and sent to drivers.
// RULE_14: Software keeps transmitter control bit 7 at zero and bit 4 at one.
// RULE_15: Software keeps driver conductance bits 7..6 at zero.
// RULE_16: Writes to the CRC result high byte have no effect.
`timescale 1ns/10ps
`include "rftxc_cfg.svh"
module rftxc_regs
#(
  parameter int ADDR_W = 6 // Host address width.
)
(
  input wire logic I_CLK,              // System clock, 25 MHz.
  input wire logic I_RST,              // Synchronous reset, active high.
  input wire logic [ADDR_W-1:0] I_ADDR, // Register address.
  input wire logic [7:0] I_WDATA,      // Write data.
  input wire logic I_WR,               // Write strobe, one cycle.
  input wire logic I_RD,               // Read strobe, one cycle.
  output logic [7:0] O_RDATA,          // Read data, one cycle after I_RD.
  input wire logic [7:0] I_CRC_HIGH,   // CRC engine result high byte.
  input wire logic I_CRC_DONE,         // CRC done flag.
  input wire logic I_CRC_8BIT,         // CRC engine runs eight-bit mode.
  input wire logic I_RX_DONE,          // Reception complete pulse.
  input wire logic I_TX_DONE,          // Transmission complete pulse.
  input wire logic I_CARRIER,          // Carrier from the clock logic.
  input wire logic I_ENC_DATA,         // Internal encoder output.
  input wire logic I_EXT_MOD,          // External modulation pin.
  output logic [2:0] O_RX_BIT_OFFSET,  // FIFO position of first rx bit.
  output logic [2:0] O_TX_LAST_BITS,   // Bits sent of the last byte.
  output logic O_MOD_IN,               // Modulator input.
  output logic [5:0] O_COND,           // Driver conductance setting.
  output logic O_ANT_A,                // Antenna output A.
  output logic O_ANT_B                 // Antenna output B.
);

  logic [2:0] rx_off_r;
  logic [2:0] last_bits_r;
  logic [7:0] tx_ctrl_r;
  logic [5:0] cond_r;
  logic [7:0] rdata_r;
  logic wr_frame;
  rftxc_ant_if ant_bus ();

  initial
  begin
    if (ADDR_W < 5)
      $error("ADDR_W too narrow for the register map");
  end

  // Address decode for reads and writes.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
    input logic [5:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  assign wr_frame = I_WR & hit(I_ADDR, `RFTXC_OFF_BIT_FRAME);

  // Receive bit offset; a host write in the completion cycle wins.
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      rx_off_r <= 3'(`RFTXC_RST_BIT_FRAME >> `RFTXC_RXOFF_LSB);
    else if (wr_frame)
      rx_off_r <= I_WDATA[`RFTXC_RXOFF_MSB:`RFTXC_RXOFF_LSB]; // see RULE_03
    else if (I_RX_DONE)
      rx_off_r <= 3'h0; // see RULE_05
  end

  // Final byte bit count; a host write in the completion cycle wins.
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      last_bits_r <= 3'h0;
    else if (wr_frame)
      last_bits_r <= I_WDATA[`RFTXC_LAST_MSB:`RFTXC_LAST_LSB]; // see RULE_06
    else if (I_TX_DONE)
      last_bits_r <= 3'h0; // see RULE_07
  end

  // Transmitter control and conductance storage.
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      tx_ctrl_r <= `RFTXC_RST_TX_CTRL;
      cond_r <= 6'(`RFTXC_RST_COND);
    end
    else if (I_WR)
    begin
      if (hit(I_ADDR, `RFTXC_OFF_TX_CTRL))
        tx_ctrl_r <= I_WDATA; // see RULE_14
      if (hit(I_ADDR, `RFTXC_OFF_COND))
        cond_r <= I_WDATA[`RFTXC_COND_MSB:`RFTXC_COND_LSB]; // see RULE_13
    end
  end

  // Read mux; the CRC high byte has no write path at all.
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      rdata_r <= 8'h00;
    else if (I_RD)
    begin
      if (hit(I_ADDR, `RFTXC_OFF_CRC_HIGH))
        rdata_r <= I_CRC_8BIT ? 8'h00 : I_CRC_HIGH; // see RULE_01 RULE_02
      else if (hit(I_ADDR, `RFTXC_OFF_BIT_FRAME))
        rdata_r <= {1'b0, rx_off_r, 1'b0, last_bits_r};
      else if (hit(I_ADDR, `RFTXC_OFF_TX_CTRL))
        rdata_r <= tx_ctrl_r;
      else if (hit(I_ADDR, `RFTXC_OFF_COND))
        rdata_r <= {2'h0, cond_r}; // see RULE_15
      else
        rdata_r <= 8'h00;
    end
  end

  // Connections to the antenna driver.
  assign ant_bus.tx_ctrl = tx_ctrl_r;
  assign ant_bus.carrier = I_CARRIER;
  assign ant_bus.enc_data = I_ENC_DATA;
  assign ant_bus.ext_mod_raw = I_EXT_MOD;

  rftxc_antenna u_ant (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .ant (ant_bus.drv)
  );

  assign O_RDATA = rdata_r;
  assign O_RX_BIT_OFFSET = rx_off_r; // see RULE_04
  assign O_TX_LAST_BITS = last_bits_r;
  assign O_COND = cond_r;
  assign O_MOD_IN = ant_bus.mod_in;
  assign O_ANT_A = ant_bus.ant_a;
  assign O_ANT_B = ant_bus.ant_b;

  // Checks on the register behaviour.
  a_rx_off_clear: assert property ( // see RULE_05
    @(posedge I_CLK) disable iff (I_RST)
    I_RX_DONE && !wr_frame |=> O_RX_BIT_OFFSET == 3'h0)
    else $error("receive offset not cleared");
  a_last_clear: assert property ( // see RULE_07
    @(posedge I_CLK) disable iff (I_RST)
    I_TX_DONE && !wr_frame |=> O_TX_LAST_BITS == 3'h0)
    else $error("last bit count not cleared");
  a_frame_write: assert property ( // see RULE_03
    @(posedge I_CLK) disable iff (I_RST)
    wr_frame |=> O_RX_BIT_OFFSET == $past(I_WDATA[6:4])
      && O_TX_LAST_BITS == $past(I_WDATA[2:0]))
    else $error("frame fields not written");

  // Checks on the CRC high byte and the conductance setting.
  a_crc_read: assert property ( // see RULE_01
    @(posedge I_CLK) disable iff (I_RST)
    I_RD && hit(I_ADDR, `RFTXC_OFF_CRC_HIGH) && !I_CRC_8BIT
      |=> O_RDATA == $past(I_CRC_HIGH))
    else $error("crc high byte read wrong");
  a_crc_narrow: assert property ( // see RULE_02
    @(posedge I_CLK) disable iff (I_RST)
    I_RD && hit(I_ADDR, `RFTXC_OFF_CRC_HIGH) && I_CRC_8BIT
      |=> O_RDATA == 8'h00)
    else $error("crc high byte not zero in narrow mode");
  a_crc_ro: assert property ( // see RULE_16
    @(posedge I_CLK) disable iff (I_RST)
    I_WR && hit(I_ADDR, `RFTXC_OFF_CRC_HIGH)
      |=> $stable(tx_ctrl_r) && $stable(cond_r))
    else $error("crc high byte write had effect");
  a_cond_apply: assert property ( // see RULE_13
    @(posedge I_CLK) disable iff (I_RST)
    I_WR && hit(I_ADDR, `RFTXC_OFF_COND) |=> O_COND == $past(I_WDATA[5:0]))
    else $error("conductance not applied");

  // Checks on the modulator source, one cycle behind the control register.
  a_mod_low: assert property ( // see RULE_08
    @(posedge I_CLK) disable iff (I_RST)
    tx_ctrl_r[6:5] == 2'h0 [*2] |-> !O_MOD_IN)
    else $error("modulator not low");
  a_mod_high: assert property ( // see RULE_08
    @(posedge I_CLK) disable iff (I_RST)
    tx_ctrl_r[6:5] == 2'h1 |=> O_MOD_IN)
    else $error("modulator not high");
  a_mod_enc: assert property ( // see RULE_08
    @(posedge I_CLK) disable iff (I_RST)
    tx_ctrl_r[6:5] == 2'h2 |=> O_MOD_IN == $past(I_ENC_DATA))
    else $error("modulator not following encoder");

  // Checks on the antenna drivers; each output lags its inputs one cycle.
  a_ant_a_off: assert property ( // see RULE_12
    @(posedge I_CLK) disable iff (I_RST)
    !tx_ctrl_r[0] |=> !O_ANT_A)
    else $error("antenna A not constant");
  a_ant_a_mod: assert property ( // see RULE_12
    @(posedge I_CLK) disable iff (I_RST)
    tx_ctrl_r[0] |=> O_ANT_A == ($past(I_CARRIER) && $past(O_MOD_IN)))
    else $error("antenna A not modulated");
  a_ant_b_off: assert property ( // see RULE_11
    @(posedge I_CLK) disable iff (I_RST)
    !tx_ctrl_r[1] |=> !O_ANT_B)
    else $error("antenna B not constant");
  a_ant_b_mod: assert property ( // see RULE_11
    @(posedge I_CLK) disable iff (I_RST)
    tx_ctrl_r[3:1] == 3'h1
      |=> O_ANT_B == ($past(I_CARRIER) && $past(O_MOD_IN)))
    else $error("antenna B not modulated");
  a_ant_b_cw: assert property ( // see RULE_10
    @(posedge I_CLK) disable iff (I_RST)
    tx_ctrl_r[3:1] == 3'h3 |=> O_ANT_B == $past(I_CARRIER))
    else $error("antenna B not continuous carrier");
  a_ant_b_inv: assert property ( // see RULE_09
    @(posedge I_CLK) disable iff (I_RST)
    tx_ctrl_r[3:1] == 3'h7 |=> O_ANT_B == !$past(I_CARRIER))
    else $error("antenna B not inverted");

  // Main scenarios that the bench should reach.
  c_rx_done: cover property (@(posedge I_CLK)
    rx_off_r != 3'h0 ##1 I_RX_DONE);
  c_tx_done: cover property (@(posedge I_CLK)
    last_bits_r != 3'h0 ##1 I_TX_DONE);
  c_ext_mod: cover property (@(posedge I_CLK)
    tx_ctrl_r[6:5] == 2'h3 && O_MOD_IN);
  c_crc_rd: cover property (@(posedge I_CLK) I_RD && I_CRC_DONE
    && hit(I_ADDR, `RFTXC_OFF_CRC_HIGH));
  c_inv_low: cover property (@(posedge I_CLK)
    tx_ctrl_r[3:1] == 3'h7 && !I_CARRIER);

endmodule : rftxc_regs

// ---- testbench/rftxc_host_model.sv ----
`timescale 1ns/10ps
module rftxc_host_model
(
  input wire logic i_clk,         // System clock.
  input wire logic [7:0] i_rdata, // Read data from the registers.
  output logic [5:0] o_addr,      // Register address.
  output logic [7:0] o_wdata,     // Write data.
  output logic o_wr,              // Write strobe.
  output logic o_rd               // Read strobe.
);
  // The bus starts idle; address and data carry no meaning yet.
  initial
  begin
    o_addr = 6'h3F;
    o_wdata = 8'hAA;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One write cycle; preset bits are forced as software must keep them.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 6'h11)
    begin
      v[7] = 1'b0;
      v[4] = 1'b1;
    end
    if (a == 6'h12)
    begin
      v[7:6] = 2'h0;
    end
    @(negedge i_clk);
    o_addr = a;
    o_wdata = v;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a; // Released lines show a changed pattern.
    o_wdata = ~v;
  endtask : wr

  // One read cycle; data is taken the cycle after the strobe.
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask : rd
endmodule : rftxc_host_model

// ---- testbench/rf_tx_framing_control_regs_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(w, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s expected %h seen %h", w, e, g); end end
module rf_tx_framing_control_regs_tb_top;
  logic clk, rst, wr, rd, crc_done, crc8, rx_done, tx_done, enc, ext;
  logic mod_in, ant_a, ant_b, car;
  logic [5:0] addr, cond;
  logic [7:0] wdata, rdata, crc_high, d;
  logic [2:0] rx_off, last_bits;
  int n_errors = 0;
  int comparisons = 0;

  rftxc_regs #(.ADDR_W(6)) u_dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_CRC_HIGH(crc_high), .I_CRC_DONE(crc_done), .I_CRC_8BIT(crc8),
    .I_RX_DONE(rx_done), .I_TX_DONE(tx_done), .I_CARRIER(car),
    .I_ENC_DATA(enc), .I_EXT_MOD(ext), .O_RX_BIT_OFFSET(rx_off),
    .O_TX_LAST_BITS(last_bits), .O_MOD_IN(mod_in), .O_COND(cond),
    .O_ANT_A(ant_a), .O_ANT_B(ant_b));

  rftxc_host_model u_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  // Clock of 40 ns period.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // Gives one done pulse of one cycle on the chosen input.
  task automatic pulse(input bit is_rx);
    @(negedge clk);
    if (is_rx) rx_done = 1'b1; else tx_done = 1'b1;
    @(negedge clk);
    rx_done = 1'b0;
    tx_done = 1'b0;
  endtask : pulse

  // Cuts a hung run short.
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    logic [7:0] v;
    logic e;
    rst = 1'b1;
    {crc_done, crc8, rx_done, tx_done, enc, ext} = 6'h00;
    crc_high = 8'hA5;
    car = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    // Reset values and an unmapped address.
    u_host.rd(6'h0F, d); `CHK("frame rst", 8'h00, d)
    u_host.rd(6'h11, d); `CHK("txctl rst", 8'h58, d)
    u_host.rd(6'h12, d); `CHK("cond rst", 8'h3F, d)
    `CHK("cond pin rst", 6'h3F, cond)
    u_host.rd(6'h20, d); `CHK("unmapped", 8'h00, d)
    // Receive offset values, final count, reserved bits and clears.
    for (int n = 0; n < 8; n += (n == 1) ? 6 : 1)
    begin
      u_host.wr(6'h0F, {1'b0, n[2:0], 4'h0});
      `CHK("rx offset", n[2:0], rx_off)
    end
    u_host.wr(6'h0F, 8'hFD);
    u_host.rd(6'h0F, d); `CHK("frame rd", 8'h75, d)
    `CHK("last bits", 3'h5, last_bits)
    pulse(1'b1);
    `CHK("rx clear", 3'h0, rx_off)
    `CHK("last kept", 3'h5, last_bits)
    pulse(1'b0);
    `CHK("tx clear", 3'h0, last_bits)
    // CRC high byte: valid value, write ignored, eight-bit mode.
    crc_done = 1'b1;
    u_host.rd(6'h0E, d); `CHK("crc high", 8'hA5, d)
    u_host.wr(6'h0E, 8'h3C);
    u_host.rd(6'h0E, d); `CHK("crc no wr", 8'hA5, d)
    crc8 = 1'b1;
    u_host.rd(6'h0E, d); `CHK("crc 8bit", 8'h00, d)
    // Conductance setting.
    u_host.wr(6'h12, 8'h15);
    u_host.rd(6'h12, d); `CHK("cond rd", 8'h15, d)
    `CHK("cond pin", 6'h15, cond)
    // Every modulator source with both antennas modulated.
    for (int s = 0; s < 4; s++)
      for (int b = 0; b < 2; b++)
      begin
        enc = b[0];
        ext = b[0];
        u_host.wr(6'h11, {1'b0, s[1:0], 5'h13});
        repeat (6) @(negedge clk);
        e = (s == 0) ? 1'b0 : (s == 1) ? 1'b1 : b[0];
        `CHK("mod in", e, mod_in)
        `CHK("ant a", e, ant_a)
        `CHK("ant b", e, ant_b)
      end
    // Carrier only, inverted, and disabled outputs with a low modulator.
    for (int k = 0; k < 3; k++)
    begin
      v = (k == 0) ? 8'h16 : (k == 1) ? 8'h1E : 8'h1C;
      u_host.wr(6'h11, v);
      repeat (4) @(negedge clk);
      `CHK("ant a off", 1'b0, ant_a)
      `CHK("ant b cw", (k == 0), ant_b)
    end
    // Carrier low: plain output follows it, inverted output goes high.
    car = 1'b0;
    u_host.wr(6'h11, 8'h16);
    repeat (4) @(negedge clk);
    `CHK("ant b cw low", 1'b0, ant_b)
    u_host.wr(6'h11, 8'h1E);
    repeat (4) @(negedge clk);
    `CHK("ant b inv low", 1'b1, ant_b)
    complete_run();
  end
endmodule : rf_tx_framing_control_regs_tb_top
